// [scan_tap_pkg.sv]
// shared constants for the boundary-scan test access port and its controller
package scan_tap_pkg;
    localparam int IR_WIDTH = 3;
    localparam int ID_WIDTH = 32;
    localparam int BSR_LENGTH = 16;
    localparam int BSR_OE_CELL = 15;
    localparam int RESET_TMS_EDGES = 5;
    localparam logic [2:0] INSTR_EXTEST = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LSBS = 2'h1;
    // arbitrary identification value, names no maker or part
    localparam logic [31:0] ID_CODE_DEFAULT = 32'h1234_5679;
    localparam int TCK_DIV_HALF = 2;
    typedef enum logic [3:0] {
        ST_RESET      = 4'h0,
        ST_IDLE       = 4'h1,
        ST_SEL_DR     = 4'h3,
        ST_CAPTURE_DR = 4'h2,
        ST_SHIFT_DR   = 4'h6,
        ST_EXIT1_DR   = 4'h7,
        ST_PAUSE_DR   = 4'h5,
        ST_EXIT2_DR   = 4'h4,
        ST_UPDATE_DR  = 4'hc,
        ST_SEL_IR     = 4'hd,
        ST_CAPTURE_IR = 4'hf,
        ST_SHIFT_IR   = 4'he,
        ST_EXIT1_IR   = 4'ha,
        ST_PAUSE_IR   = 4'hb,
        ST_EXIT2_IR   = 4'h9,
        ST_UPDATE_IR  = 4'h8
    } tap_state_type;
endpackage

// [scan_link_if.sv]
// serial link between the scan controller and the test access port
`timescale 1ns/100ps
interface scan_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic tms_oe;
    logic tdi_oe;
    // pulled-up wires read high when undriven; undriven data out reads high too
    wire tms_line = tms_oe ? tms : 1'b1;
    wire tdi_line = tdi_oe ? tdi : 1'b1;
    wire tdo_line = tdo_oe ? tdo : 1'b1;
    modport device (input tck, input tms_line, input tdi_line, output tdo, output tdo_oe);
    modport host (output tck, output tms, output tdi, output tms_oe, output tdi_oe, input tdo_line);
endinterface

// [scan_tap.sv]
// boundary-scan test access port of the memory device
// Functional notes
// - sample rising edge, drive output falling
// - unconnected mode and data inputs read high
// - data enters MSB, leaves LSB
// - power-up reset, data output high-Z
// - five mode-high edges reset the port
// - instruction selects exactly one scan register
// - three-bit instruction, identify on reset
// - capture-IR loads 01 into low bits
// - one-bit bypass, cleared under bypass
// - boundary register captures ring, shifts
// - identification register captures fixed 32-bit code
// - identification code shifts out in Shift-DR
// - controller loads reserved codes too; they select bypass
// - instruction takes effect at Update-IR
// - external test drives preloaded values out
// - sample-high-Z tri-states all memory outputs
// - unused port keeps test clock low
// - sample/preload snapshots pins, shifts preload
// - bypass is sole element under bypass
// - enable cell drives bus, presets high
`timescale 1ns/100ps
module scan_tap #(
    parameter int          BSR_LEN = scan_tap_pkg::BSR_LENGTH,
    parameter logic [31:0] ID_CODE = scan_tap_pkg::ID_CODE_DEFAULT
) (
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    scan_link_if.device             link,
    input  wire logic [BSR_LEN-1:0] pins_i,
    input  wire logic [BSR_LEN-2:0] core_i,
    output logic      [BSR_LEN-2:0] pins_o,
    output logic                    pins_oe_o,
    output logic      [2:0]         instr_o
);
    // tap logic runs on the link clock; clk_i only retimes the pin drive, pin enable and instruction outputs
    scan_tap_pkg::tap_state_type state_q, state_d;
    logic [2:0]          ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic                byp_q, byp_d;
    logic [31:0]         id_q, id_d;
    logic [BSR_LEN-1:0]  bsr_q, bsr_d, upd_q, upd_d;
    logic                tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
    logic                tms, tdi;
    logic                use_bsr;

    assign tms = link.tms_line;
    assign tdi = link.tdi_line;
    assign use_bsr = (ir_q == scan_tap_pkg::INSTR_EXTEST) || (ir_q == scan_tap_pkg::INSTR_SAMPLE)
                     || (ir_q == scan_tap_pkg::INSTR_SAMPLE_Z);

    always_comb begin
        state_d = state_q;
        case (state_q)
            scan_tap_pkg::ST_RESET:      state_d = tms ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_IDLE;
            scan_tap_pkg::ST_IDLE:       state_d = tms ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
            scan_tap_pkg::ST_SEL_DR:     state_d = tms ? scan_tap_pkg::ST_SEL_IR : scan_tap_pkg::ST_CAPTURE_DR;
            scan_tap_pkg::ST_CAPTURE_DR: state_d = tms ? scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
            scan_tap_pkg::ST_SHIFT_DR:   state_d = tms ? scan_tap_pkg::ST_EXIT1_DR : scan_tap_pkg::ST_SHIFT_DR;
            scan_tap_pkg::ST_EXIT1_DR:   state_d = tms ? scan_tap_pkg::ST_UPDATE_DR : scan_tap_pkg::ST_PAUSE_DR;
            scan_tap_pkg::ST_PAUSE_DR:   state_d = tms ? scan_tap_pkg::ST_EXIT2_DR : scan_tap_pkg::ST_PAUSE_DR;
            scan_tap_pkg::ST_EXIT2_DR:   state_d = tms ? scan_tap_pkg::ST_UPDATE_DR : scan_tap_pkg::ST_SHIFT_DR;
            scan_tap_pkg::ST_UPDATE_DR:  state_d = tms ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
            scan_tap_pkg::ST_SEL_IR:     state_d = tms ? scan_tap_pkg::ST_RESET : scan_tap_pkg::ST_CAPTURE_IR;
            scan_tap_pkg::ST_CAPTURE_IR: state_d = tms ? scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
            scan_tap_pkg::ST_SHIFT_IR:   state_d = tms ? scan_tap_pkg::ST_EXIT1_IR : scan_tap_pkg::ST_SHIFT_IR;
            scan_tap_pkg::ST_EXIT1_IR:   state_d = tms ? scan_tap_pkg::ST_UPDATE_IR : scan_tap_pkg::ST_PAUSE_IR;
            scan_tap_pkg::ST_PAUSE_IR:   state_d = tms ? scan_tap_pkg::ST_EXIT2_IR : scan_tap_pkg::ST_PAUSE_IR;
            scan_tap_pkg::ST_EXIT2_IR:   state_d = tms ? scan_tap_pkg::ST_UPDATE_IR : scan_tap_pkg::ST_SHIFT_IR;
            scan_tap_pkg::ST_UPDATE_IR:  state_d = tms ? scan_tap_pkg::ST_SEL_DR : scan_tap_pkg::ST_IDLE;
            default:                     state_d = scan_tap_pkg::ST_RESET;
        endcase
    end

    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        byp_d   = byp_q;
        id_d    = id_q;
        bsr_d   = bsr_q;
        upd_d   = upd_q;
        case (state_q)
            scan_tap_pkg::ST_RESET: begin
                ir_d = scan_tap_pkg::INSTR_IDCODE;
                upd_d[scan_tap_pkg::BSR_OE_CELL] = 1'b1;
            end
            scan_tap_pkg::ST_CAPTURE_IR: ir_sh_d = {ir_q[2], scan_tap_pkg::IR_CAPTURE_LSBS};
            scan_tap_pkg::ST_SHIFT_IR:   ir_sh_d = {tdi, ir_sh_q[2:1]};
            scan_tap_pkg::ST_UPDATE_IR:  ir_d = ir_sh_q;
            scan_tap_pkg::ST_CAPTURE_DR: begin
                if (ir_q == scan_tap_pkg::INSTR_BYPASS) begin
                    byp_d = 1'b0;
                end
                if (ir_q == scan_tap_pkg::INSTR_IDCODE) begin
                    id_d = ID_CODE;
                end
                if (use_bsr) begin
                    bsr_d = pins_i;
                end
            end
            scan_tap_pkg::ST_SHIFT_DR: begin
                if (ir_q == scan_tap_pkg::INSTR_BYPASS) begin
                    byp_d = tdi;
                end else if (ir_q == scan_tap_pkg::INSTR_IDCODE) begin
                    id_d = {tdi, id_q[31:1]};
                end else if (use_bsr) begin
                    bsr_d = {tdi, bsr_q[BSR_LEN-1:1]};
                end else begin
                    byp_d = tdi;
                end
            end
            scan_tap_pkg::ST_UPDATE_DR: begin
                if (use_bsr) begin
                    upd_d = bsr_q;
                end
            end
            default: begin
            end
        endcase
        // act on entry: the link clock may stop right after the fifth mode-high edge
        if (state_d == scan_tap_pkg::ST_RESET) begin
            ir_d = scan_tap_pkg::INSTR_IDCODE;
            upd_d[scan_tap_pkg::BSR_OE_CELL] = 1'b1;
        end
    end

    // data out chosen combinationally, retimed on the falling edge
    always_comb begin
        tdo_d    = 1'b0;
        tdo_oe_d = 1'b0;
        if (state_q == scan_tap_pkg::ST_SHIFT_IR) begin
            tdo_d    = ir_sh_q[0];
            tdo_oe_d = 1'b1;
        end else if (state_q == scan_tap_pkg::ST_SHIFT_DR) begin
            tdo_oe_d = 1'b1;
            if (ir_q == scan_tap_pkg::INSTR_IDCODE) begin
                tdo_d = id_q[0];
            end else if (use_bsr) begin
                tdo_d = bsr_q[0];
            end else begin
                tdo_d = byp_q;
            end
        end
    end

    // power-up reset on nrst_i; tms-high reset walks the state machine home
    always_ff @(posedge link.tck or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= scan_tap_pkg::ST_RESET;
            ir_sh_q <= 3'h0;
            ir_q    <= scan_tap_pkg::INSTR_IDCODE;
            byp_q   <= 1'b0;
            id_q    <= 32'h0000_0000;
            bsr_q   <= '0;
            upd_q   <= {1'b1, {(BSR_LEN-1){1'b0}}};
        end else begin
            state_q <= state_d;
            ir_sh_q <= ir_sh_d;
            ir_q    <= ir_d;
            byp_q   <= byp_d;
            id_q    <= id_d;
            bsr_q   <= bsr_d;
            upd_q   <= upd_d;
        end
    end

    always_ff @(negedge link.tck or negedge nrst_i) begin
        if (!nrst_i) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end
    assign link.tdo    = tdo_q;
    assign link.tdo_oe = tdo_oe_q;

    // pin drive computed in link domain, then two-flop into clk_i domain
    logic [BSR_LEN-2:0] pin_val;
    logic               pin_en;
    logic [BSR_LEN-1:0] sync1_q, sync2_q, sync1_d, sync2_d;
    logic [2:0]         ins1_q, ins2_q;
    always_comb begin
        pin_val = core_i;
        pin_en  = 1'b1;
        if (ir_q == scan_tap_pkg::INSTR_EXTEST) begin
            pin_val = upd_q[BSR_LEN-2:0];
            pin_en  = upd_q[scan_tap_pkg::BSR_OE_CELL];
        end else if (ir_q == scan_tap_pkg::INSTR_SAMPLE_Z) begin
            pin_en = 1'b0;
        end
        sync1_d = {pin_en, pin_val};
        sync2_d = sync1_q;
    end
    // limitation: multi-bit values may tear for one cycle around an update
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_q   <= '0;
            sync2_q   <= '0;
            ins1_q    <= 3'h0;
            ins2_q    <= 3'h0;
            pins_o    <= '0;
            pins_oe_o <= 1'b0;
            instr_o   <= 3'h0;
        end else begin
            sync1_q   <= sync1_d;
            sync2_q   <= sync2_d;
            ins1_q    <= ir_q;
            ins2_q    <= ins1_q;
            pins_o    <= sync2_q[BSR_LEN-2:0];
            pins_oe_o <= sync2_q[BSR_LEN-1];
            instr_o   <= ins2_q;
        end
    end
endmodule

// [scan_ctrl.sv]
// scan controller end: generates the test clock and walks the port by request
`timescale 1ns/100ps
module scan_ctrl (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    scan_link_if.host        link,
    input  wire logic        go_i,
    input  wire logic        park_i,
    input  wire logic [5:0]  len_i,
    input  wire logic [31:0] tms_i,
    input  wire logic [31:0] tdi_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [31:0]      tdo_o
);
    // each step presents one tms/tdi bit per link clock; caller owns the sequence
    logic [1:0]  div_q, div_d;
    logic        tck_q, tck_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [31:0] tms_q, tms_d, tdi_q, tdi_d, cap_q, cap_d;
    logic        busy_q, busy_d, done_q, done_d, out_q, out_d;
    logic        tdo_s1_q, tdo_s2_q;

    always_comb begin
        div_d  = div_q;
        tck_d  = tck_q;
        cnt_d  = cnt_q;
        tms_d  = tms_q;
        tdi_d  = tdi_q;
        cap_d  = cap_q;
        busy_d = busy_q;
        done_d = 1'b0;
        out_d  = out_q;
        if (!busy_q) begin
            tck_d = 1'b0;
            div_d = 2'h0;
            if (go_i && len_i != 6'h00) begin
                busy_d = 1'b1;
                cnt_d  = len_i;
                tms_d  = tms_i;
                tdi_d  = tdi_i;
                cap_d  = 32'h0000_0000;
                out_d  = 1'b1;
            end
            if (park_i) begin
                out_d = 1'b0;
            end
        end else if (div_q == 2'(scan_tap_pkg::TCK_DIV_HALF - 1)) begin
            div_d = 2'h0;
            tck_d = ~tck_q;
            if (tck_q) begin
                // falling edge: next bit; two-flop delay still shows the bit that stood at the rise
                cap_d = {tdo_s2_q, cap_q[31:1]};
                tms_d = {1'b0, tms_q[31:1]};
                tdi_d = {1'b0, tdi_q[31:1]};
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end
            end
        end else begin
            div_d = div_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q    <= 2'h0;
            tck_q    <= 1'b0;
            cnt_q    <= 6'h00;
            tms_q    <= 32'h0000_0000;
            tdi_q    <= 32'h0000_0000;
            cap_q    <= 32'h0000_0000;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            out_q    <= 1'b0;
            tdo_s1_q <= 1'b1;
            tdo_s2_q <= 1'b1;
        end else begin
            div_q    <= div_d;
            tck_q    <= tck_d;
            cnt_q    <= cnt_d;
            tms_q    <= tms_d;
            tdi_q    <= tdi_d;
            cap_q    <= cap_d;
            busy_q   <= busy_d;
            done_q   <= done_d;
            out_q    <= out_d;
            tdo_s1_q <= link.tdo_line;
            tdo_s2_q <= tdo_s1_q;
        end
    end
    assign link.tck    = tck_q;
    assign link.tms    = tms_q[0];
    assign link.tdi    = tdi_q[0];
    assign link.tms_oe = out_q;
    assign link.tdi_oe = out_q;
    assign busy_o      = busy_q;
    assign done_o      = done_q;
    assign tdo_o       = cap_q;
endmodule

// [scan_link_sva.sv]
// link checker: controller state shadow and timing/data relations on the scan link
`timescale 1ns/100ps
module scan_link_sva #(
    parameter logic [31:0] ID_CODE = scan_tap_pkg::ID_CODE_DEFAULT
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tck,
    input wire logic tms_oe,
    input wire logic tms_line,
    input wire logic tdi_line,
    input wire logic tdo_oe,
    input wire logic tdo_line
);
    // next state per state code, one nibble each; tables beat a sixteen-way case
    localparam logic [63:0] NXT0 = 64'hEEF1_BBE1_5656_2611;
    localparam logic [63:0] NXT1 = 64'hAA03_9883_C74C_D730;
    logic [3:0] st_q, st_d;
    logic [7:0] idx_q, idx_d;
    logic [2:0] sh_q, sh_d, ir_q, ir_d, hi_q, hi_d;
    logic       in_dr, in_ir;
    always_comb begin
        in_dr = st_q == scan_tap_pkg::ST_SHIFT_DR;
        in_ir = st_q == scan_tap_pkg::ST_SHIFT_IR;
        st_d  = tms_line ? NXT1[{st_q, 2'b00} +: 4] : NXT0[{st_q, 2'b00} +: 4];
        idx_d = (in_dr || in_ir) ? idx_q + 8'h01 : 8'h00;
        sh_d  = in_ir ? {tdi_line, sh_q[2:1]} : sh_q;
        ir_d  = st_q == scan_tap_pkg::ST_UPDATE_IR ? sh_q : ir_q;
        if (st_d == scan_tap_pkg::ST_RESET) begin
            ir_d = scan_tap_pkg::INSTR_IDCODE;
        end
        hi_d  = !tms_line ? 3'h0 : (hi_q == 3'h4 ? hi_q : hi_q + 3'h1);
    end
    always_ff @(posedge tck or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q  <= scan_tap_pkg::ST_RESET;
            idx_q <= 8'h00;
            sh_q  <= 3'h0;
            ir_q  <= scan_tap_pkg::INSTR_IDCODE;
            hi_q  <= 3'h0;
        end else begin
            st_q  <= st_d;
            idx_q <= idx_d;
            sh_q  <= sh_d;
            ir_q  <= ir_d;
            hi_q  <= hi_d;
        end
    end
    property p_out_edge;
        @(posedge clk_i) disable iff (!nrst_i) $changed(tdo_line) |-> $fell(tck);
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("data out moved off falling edge");
    property p_reset_hiz;
        @(posedge clk_i) disable iff (!nrst_i) $rose(nrst_i) |-> !tdo_oe;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("data out driven after reset");
    property p_pull;
        @(posedge clk_i) disable iff (!nrst_i) !tms_oe |-> tms_line;
    endproperty
    a_pull: assert property (p_pull) else $error("released mode line not high");
    property p_oe_shift;
        @(posedge tck) disable iff (!nrst_i) tdo_oe == (in_dr || in_ir);
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("data out enable off shift");
    property p_ir_capture;
        @(posedge tck) disable iff (!nrst_i) in_ir && idx_q < 8'h02 |-> tdo_line == (idx_q == 8'h00);
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("captured low bits not 01");
    property p_id_shift;
        @(posedge tck) disable iff (!nrst_i)
            in_dr && ir_q == scan_tap_pkg::INSTR_IDCODE && idx_q < 8'h20 |-> tdo_line == ID_CODE[idx_q[4:0]];
    endproperty
    a_id_shift: assert property (p_id_shift) else $error("identification bit wrong");
    property p_byp_clear;
        @(posedge tck) disable iff (!nrst_i) in_dr && ir_q == scan_tap_pkg::INSTR_BYPASS && idx_q == 8'h00 |-> !tdo_line;
    endproperty
    a_byp_clear: assert property (p_byp_clear) else $error("bypass not cleared");
    property p_byp_path;
        @(posedge tck) disable iff (!nrst_i)
            in_dr && ir_q == scan_tap_pkg::INSTR_BYPASS && idx_q != 8'h00 |-> tdo_line == $past(tdi_line);
    endproperty
    a_byp_path: assert property (p_byp_path) else $error("bypass path not one bit");
    property p_five;
        @(posedge tck) disable iff (!nrst_i) hi_q == 3'h4 && tms_line |=> !tdo_oe [*2];
    endproperty
    a_five: assert property (p_five) else $error("port not reset by mode high");
endmodule

// [sram_boundary_scan_tap_bench.sv]
// bench: scan controller walks the test access port through its instructions
`timescale 1ns/100ps
module sram_boundary_scan_tap_bench;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        go = 1'b0;
    logic        park = 1'b0;
    logic [5:0]  len = 6'h0;
    logic [31:0] tmsv = 32'h0;
    logic [31:0] tdiv = 32'h0;
    logic [15:0] pins = 16'h5A3C;
    logic [14:0] core = 15'h1234;
    logic        busy;
    logic        done;
    logic [31:0] tdo;
    logic [14:0] pout;
    logic        poe;
    logic [2:0]  instr;
    logic [31:0] rd;
    logic [2:0]  cur = scan_tap_pkg::INSTR_IDCODE;
    int          n_mismatch = 0;
    int          tests_run = 0;
    always #50 clk = ~clk;
    scan_link_if link ();
    scan_ctrl u_scan_ctrl (.clk_i(clk), .nrst_i(nrst), .link(link), .go_i(go), .park_i(park), .len_i(len),
        .tms_i(tmsv), .tdi_i(tdiv), .busy_o(busy), .done_o(done), .tdo_o(tdo));
    scan_tap u_scan_tap (.clk_i(clk), .nrst_i(nrst), .link(link), .pins_i(pins), .core_i(core),
        .pins_o(pout), .pins_oe_o(poe), .instr_o(instr));
    scan_link_sva u_scan_link_sva (.clk_i(clk), .nrst_i(nrst), .tck(link.tck), .tms_oe(link.tms_oe),
        .tms_line(link.tms_line), .tdi_line(link.tdi_line), .tdo_oe(link.tdo_oe), .tdo_line(link.tdo_line));
    task automatic report_and_stop;
        $display("mismatches %0d compares %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one controller frame; result right-aligned since bits arrive from the top
    task automatic run(input logic [5:0] n, input logic [31:0] t, input logic [31:0] d);
        int k;
        k = 0;
        len <= n;
        tmsv <= t;
        tdiv <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (k >= 400) n_mismatch++;
        chk({busy, link.tck}, 2'b00);
        rd = tdo >> (32 - n);
    endtask
    // instruction crosses a two-flop retimer before the pins follow
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask
    task automatic scan_ir(input logic [2:0] c);
        run(6'd5, 32'h6, 32'h0);
        run(6'd3, 32'h4, {29'h0, c});
        chk(rd[1:0], 2'b01);
        chk(instr, cur);
        run(6'd2, 32'h1, 32'h0);
        settle();
        chk(instr, c);
        cur = c;
    endtask
    task automatic scan_dr(input logic [5:0] n, input logic [31:0] d, input logic [31:0] exp);
        run(6'd4, 32'h2, 32'h0);
        run(n, 32'h1 << (n - 6'd1), d);
        chk(rd, exp);
        run(6'd2, 32'h1, 32'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(link.tdo_oe, 1'b0);
        scan_dr(6'd32, 32'h0, scan_tap_pkg::ID_CODE_DEFAULT);
        chk(instr, scan_tap_pkg::INSTR_IDCODE);
        park <= 1'b1;
        settle();
        chk(link.tms_line, 1'b1);
        chk(link.tdi_line, 1'b1);
        park <= 1'b0;
        settle();
        scan_ir(scan_tap_pkg::INSTR_BYPASS);
        scan_dr(6'd8, 32'hA5, 32'h4A);
        run(6'd4, 32'h2, 32'h0);
        run(6'd5, 32'h1F, 32'h0);
        settle();
        chk(instr, scan_tap_pkg::INSTR_IDCODE);
        cur = scan_tap_pkg::INSTR_IDCODE;
        scan_ir(scan_tap_pkg::INSTR_SAMPLE);
        scan_dr(6'd16, 32'hC0DE, 32'h5A3C);
        chk(pout, core);
        chk(poe, 1'b1);
        scan_ir(scan_tap_pkg::INSTR_SAMPLE_Z);
        chk(poe, 1'b0);
        scan_ir(scan_tap_pkg::INSTR_EXTEST);
        chk(pout, 15'h40DE);
        chk(poe, 1'b1);
        scan_dr(6'd16, 32'h1234, 32'h5A3C);
        settle();
        chk(poe, 1'b0);
        report_and_stop();
    end
    // about thirty times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
